// ===== cfx_executor.sv
`include "cfx_params.svh"
`default_nettype none

module cfx_fifo #(
    parameter int W = 64,
    parameter int D = 16
) (
    input wire logic clk_in, // clock
    input wire logic rst_in, // async reset
    input wire logic in_valid_in, // push request
    output logic in_ready_out, // room left
    input wire logic [W-1:0] in_data_in, // push word
    output logic out_valid_out, // word present
    input wire logic out_ready_in, // pop request
    output logic [W-1:0] out_data_out // head word
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    logic [W-1:0] mem [0:D-1]; // storage
    logic [AW-1:0] wp; // write index
    logic [AW-1:0] rp; // read index
    logic [AW:0] cnt; // fill level
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    assign in_ready_out = cnt != FULL;
    assign out_valid_out = cnt != '0;
    assign out_data_out = mem[rp];

    // storage needs no reset, only pointers and fill count do
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp] <= in_data_in;
        end
    end

    // pointers wrap at the power-of-two depth
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= push ? wp + 1'b1 : wp;
            rp <= pop ? rp + 1'b1 : rp;
            cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : cfx_fifo

module cfx_executor #(
    parameter logic [3:0] ID_CODE = 4'h6 // arbitrary id value
) (
    input wire logic sys_clk_in, // 40 MHz clock
    input wire logic rst_in, // async reset, high
    input wire logic fn_valid_in, // function packet offered
    input wire cfx_pkg::cfx_pkt_t fn_pkt_in, // packet parcels
    output logic fn_ready_out, // packet taken when idle
    output logic resp_pulse_out, // channel response pulse
    output logic [31:0] resp_data_out, // response data word
    output logic [15:0] crr_out, // call response register
    input wire logic dpulse_in, // data pulse from node
    output logic dpulse_out, // data pulse to node
    input wire logic rx_valid_in, // inbound word valid
    input wire logic [63:0] rx_data_in, // inbound word
    output logic rx_ready_out, // inbound word taken
    output logic tx_valid_out, // outbound word valid
    output logic [63:0] tx_data_out, // outbound word
    input wire logic tx_ready_in, // outbound word taken
    output cfx_pkg::cfx_mem_t mem_out, // memory request
    input wire logic mem_ack_in, // memory word done
    input wire logic [63:0] mem_rdata_in, // read data
    input wire logic [31:0] pc_in, // current program address
    input wire logic [31:0] status_in, // status register
    input wire logic [31:0] errdata_in, // error data register
    output cfx_pkg::cfx_cmd_t cmd_out // core commands
);
    cfx_pkg::cfx_state_t st; // sequencer state
    cfx_pkg::cfx_pkt_t pkt; // captured packet
    cfx_pkg::cfx_cmd_t cmd; // core command pulses
    logic [63:0] fbuf [0:63];
    logic [9:0] len; // reference length
    logic [31:0] mar; // memory reference address
    logic [31:0] acp; // segment base copy
    logic [31:0] cur; // current word address
    logic [31:0] ref_hi; // upper reference register
    logic [31:0] ref_lo; // lower reference register
    logic [6:0] idx; // word index in segment
    logic [31:0] resp_data; // response word
    logic [15:0] crr; // call response register

    // words in this segment, capped at 64
    function automatic logic [6:0] seg_of(input logic [9:0] l);
        seg_of = (l >= `CFX_SEG_LEN) ? `CFX_SEG_W : l[6:0];
    endfunction : seg_of

    wire id_hit = {fn_pkt_in.p1[15:14], fn_pkt_in.p1[8:7]} == ID_CODE;
    wire [4:0] fn = pkt.p1[13:9]; // function field
    wire [1:0] sub = pkt.p1[1:0]; // subfunction field
    wire [15:0] p2 = pkt.p2; // second parcel
    // parcel three is the high half
    wire [31:0] v32 = {pkt.p3, pkt.p4};
    wire [6:0] seg = seg_of(len);
    wire seg_nz = seg != 7'h00;
    wire last = idx == (seg - 7'h01);
    wire big = len >= `CFX_SEG_LEN;
    wire is_rd = fn == `CFX_FN_BLKRD;
    wire mem_st = st == cfx_pkg::S_MRD || st == cfx_pkg::S_MWR;
    // a zero length moves nothing and ends at once
    wire mem_done = !seg_nz || (mem_ack_in && last);
    wire fifo_rdy;
    wire send_go = st == cfx_pkg::S_SEND && seg_nz;
    wire send_done = !seg_nz || (fifo_rdy && last);
    wire rx_go = st == cfx_pkg::S_RECV && rx_valid_in;
    wire rx_done = !seg_nz || (rx_valid_in && last);

    // register chosen by the subfunction
    wire [31:0] rd_sel = (sub == `CFX_SUB_STAT) ? status_in :
                         (sub == `CFX_SUB_MAR) ? mar :
                         (sub == `CFX_SUB_ERR) ? errdata_in : 32'h0000_0000;

    // buffer write port: memory, channel or references
    wire bw_mrd = st == cfx_pkg::S_MRD && mem_ack_in;
    wire bw_dec = st == cfx_pkg::S_DEC &&
                  (fn == `CFX_FN_WRW || fn == `CFX_FN_BSET);
    wire buf_we = bw_mrd || rx_go || bw_dec;
    // word zero for the single-word store
    // word picked by the second parcel
    wire [5:0] buf_wa = !bw_dec ? idx[5:0] :
                        (fn == `CFX_FN_BSET) ? p2[5:0] : 6'h00;
    wire [63:0] buf_wd = bw_mrd ? mem_rdata_in :
                         rx_go ? rx_data_in : {ref_hi, ref_lo};
    // register save takes live core values, zero filled
    wire [31:0] sv_word = (idx == 7'h00) ? pc_in : status_in;
    wire [63:0] wr_word = (fn == `CFX_FN_STREG) ?
                          {32'h0000_0000, sv_word} : fbuf[idx[5:0]];

    assign fn_ready_out = st == cfx_pkg::S_IDLE;
    assign resp_pulse_out = st == cfx_pkg::S_RESP;
    assign dpulse_out = st == cfx_pkg::S_PULSE;
    assign rx_ready_out = st == cfx_pkg::S_RECV;
    assign resp_data_out = resp_data;
    assign crr_out = crr;
    assign cmd_out = cmd;
    assign mem_out.req = mem_st && seg_nz;
    assign mem_out.we = st == cfx_pkg::S_MWR;
    assign mem_out.addr = cur;
    assign mem_out.wdata = wr_word;

    // outbound words pass a small fifo so a slow node stalls sending
    cfx_fifo #(.W(64), .D(`CFX_FIFO_DEPTH)) u_txq (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_valid_in(send_go),
        .in_ready_out(fifo_rdy),
        .in_data_in(fbuf[idx[5:0]]),
        .out_valid_out(tx_valid_out),
        .out_ready_in(tx_ready_in),
        .out_data_out(tx_data_out)
    );

    // buffer storage, data only, no reset
    always_ff @(posedge sys_clk_in) begin
        if (buf_we) begin
            fbuf[buf_wa] <= buf_wd;
        end
    end

    // sequencer
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st <= cfx_pkg::S_IDLE;
            pkt <= '0;
            cmd <= '0;
            len <= '0;
            mar <= '0;
            acp <= '0;
            cur <= '0;
            ref_hi <= '0;
            ref_lo <= '0;
            idx <= '0;
            resp_data <= '0;
            crr <= '0;
        end else begin
            // core commands are single-cycle pulses
            cmd <= '0;
            case (st)
                cfx_pkg::S_IDLE: begin
                    if (fn_valid_in && id_hit) begin
                        pkt <= fn_pkt_in;
                        st <= cfx_pkg::S_DEC;
                    end
                end
                cfx_pkg::S_DEC: begin
                    resp_data <= '0;
                    idx <= '0;
                    cur <= v32;
                    acp <= v32;
                    st <= cfx_pkg::S_RESP;
                    case (fn)
                        `CFX_FN_RESTART: begin
                            crr <= p2;
                            cmd.start <= 1'b1;
                        end
                        `CFX_FN_STOP: begin
                            cmd.stop <= 1'b1;
                        end
                        `CFX_FN_RDP: begin
                            resp_data <= pc_in;
                        end
                        `CFX_FN_LDP: begin
                            cmd.p_load <= 1'b1;
                            cmd.pval <= v32;
                        end
                        `CFX_FN_RDREG: begin
                            resp_data <= rd_sel;
                        end
                        `CFX_FN_WRREG: begin
                            crr <= p2;
                            mar <= (sub == `CFX_SUB_MAR) ? v32 : mar;
                            cmd.st_we <= sub == `CFX_SUB_STAT;
                            cmd.er_we <= sub == `CFX_SUB_ERR;
                            cmd.rval <= v32;
                        end
                        `CFX_FN_BLKRD: begin
                            len <= p2[9:0];
                            mar <= v32;
                            st <= cfx_pkg::S_MRD;
                        end
                        `CFX_FN_RDW: begin
                            len <= `CFX_LEN_ONE;
                            mar <= v32;
                            st <= cfx_pkg::S_MRD;
                        end
                        `CFX_FN_RDHI: begin
                            resp_data <= ref_hi;
                        end
                        `CFX_FN_RDLO: begin
                            resp_data <= ref_lo;
                        end
                        `CFX_FN_BRD: begin
                            len <= {3'h0, p2[6:0]};
                            mar <= v32;
                            st <= cfx_pkg::S_MRD;
                        end
                        `CFX_FN_BREF: begin
                            ref_hi <= fbuf[p2[5:0]][63:32];
                            ref_lo <= fbuf[p2[5:0]][31:0];
                        end
                        `CFX_FN_BLKST: begin
                            len <= p2[9:0];
                            mar <= v32;
                        end
                        `CFX_FN_WRW: begin
                            len <= `CFX_LEN_ONE;
                            mar <= v32;
                            st <= cfx_pkg::S_MWR;
                        end
                        `CFX_FN_WRHI: begin
                            ref_hi <= v32;
                        end
                        `CFX_FN_WRLO: begin
                            ref_lo <= v32;
                        end
                        `CFX_FN_BWR: begin
                            len <= {3'h0, p2[6:0]};
                            mar <= v32;
                            st <= cfx_pkg::S_MWR;
                        end
                        `CFX_FN_BSET: begin
                            // buffer written by the write port
                            st <= cfx_pkg::S_RESP;
                        end
                        `CFX_FN_LDREG: begin
                            crr <= p2;
                            len <= `CFX_LEN_FOUR;
                            mar <= v32;
                            st <= cfx_pkg::S_MRD;
                        end
                        `CFX_FN_STREG: begin
                            len <= `CFX_LEN_TWO;
                            mar <= v32;
                            st <= cfx_pkg::S_MWR;
                        end
                        default: begin
                            // unknown code: drop without answer
                            st <= cfx_pkg::S_IDLE;
                        end
                    endcase
                end
                cfx_pkg::S_MRD: begin
                    if (mem_ack_in) begin
                        idx <= idx + 7'h01;
                        cur <= cur + 32'h0000_0001;
                    end
                    if (mem_done) begin
                        idx <= '0;
                        st <= cfx_pkg::S_RESP;
                        if (is_rd) begin
                            st <= cfx_pkg::S_PULSE;
                        end
                        if (fn == `CFX_FN_RDW) begin
                            ref_hi <= mem_rdata_in[63:32];
                            ref_lo <= mem_rdata_in[31:0];
                        end
                        // register load restarts the program
                        if (fn == `CFX_FN_LDREG) begin
                            cmd.p_load <= 1'b1;
                            cmd.pval <= fbuf[0][31:0];
                            cmd.st_we <= 1'b1;
                            cmd.rval <= fbuf[1][31:0];
                            cmd.start <= 1'b1;
                        end
                    end
                end
                cfx_pkg::S_MWR: begin
                    if (mem_ack_in) begin
                        idx <= idx + 7'h01;
                        cur <= cur + 32'h0000_0001;
                    end
                    if (mem_done) begin
                        idx <= '0;
                        st <= (fn == `CFX_FN_BLKST) ?
                              cfx_pkg::S_PULSE : cfx_pkg::S_RESP;
                    end
                end
                cfx_pkg::S_PULSE: begin
                    idx <= '0;
                    st <= is_rd ? cfx_pkg::S_SEND : cfx_pkg::S_SEG;
                end
                cfx_pkg::S_SEND: begin
                    if (send_go && fifo_rdy) begin
                        idx <= idx + 7'h01;
                    end
                    if (send_done) begin
                        idx <= '0;
                        st <= cfx_pkg::S_WAIT;
                    end
                end
                cfx_pkg::S_WAIT: begin
                    if (dpulse_in) begin
                        idx <= '0;
                        st <= is_rd ? cfx_pkg::S_SEG : cfx_pkg::S_RECV;
                    end
                end
                cfx_pkg::S_RECV: begin
                    if (rx_go) begin
                        idx <= idx + 7'h01;
                    end
                    if (rx_done) begin
                        idx <= '0;
                        cur <= acp;
                        st <= cfx_pkg::S_MWR;
                    end
                end
                cfx_pkg::S_SEG: begin
                    if (!big || len == `CFX_SEG_LEN) begin
                        st <= is_rd ? cfx_pkg::S_RESP : cfx_pkg::S_IDLE;
                    end else begin
                        st <= is_rd ? cfx_pkg::S_MRD : cfx_pkg::S_WAIT;
                    end
                    if (big) begin
                        len <= len - `CFX_SEG_LEN;
                        acp <= acp + 32'h0000_0040;
                        cur <= acp + 32'h0000_0040;
                    end
                end
                cfx_pkg::S_RESP: begin
                    // store waits for first data pulse
                    st <= (fn == `CFX_FN_BLKST) ?
                          cfx_pkg::S_WAIT : cfx_pkg::S_IDLE;
                end
                default: begin
                    st <= cfx_pkg::S_IDLE;
                end
            endcase
        end
    end

    // checks on the sequencer
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    wire in_dec = st == cfx_pkg::S_DEC;

    property p_restart;
        in_dec && fn == `CFX_FN_RESTART |=>
            cmd_out.start && resp_pulse_out && crr_out == $past(p2);
    endproperty
    a_restart: assert property (p_restart) else $error("restart wrong");

    property p_stop;
        in_dec && fn == `CFX_FN_STOP |=>
            cmd_out.stop && resp_pulse_out && resp_data_out == 32'h0000_0000;
    endproperty
    a_stop: assert property (p_stop) else $error("stop wrong");

    property p_rdp;
        in_dec && fn == `CFX_FN_RDP |=>
            resp_pulse_out && resp_data_out == $past(pc_in) && !cmd_out.stop;
    endproperty
    a_rdp: assert property (p_rdp) else $error("address read wrong");

    property p_ldp;
        in_dec && fn == `CFX_FN_LDP |=>
            cmd_out.p_load && cmd_out.pval == $past(v32);
    endproperty
    a_ldp: assert property (p_ldp) else $error("address load wrong");

    property p_rdmar;
        in_dec && fn == `CFX_FN_RDREG && sub == `CFX_SUB_MAR |=>
            resp_data_out == $past(mar);
    endproperty
    a_rdmar: assert property (p_rdmar) else $error("sub read wrong");

    property p_pulse;
        dpulse_out && is_rd |=> st == cfx_pkg::S_SEND;
    endproperty
    a_pulse: assert property (p_pulse) else $error("send not after pulse");

    property p_rdend;
        st == cfx_pkg::S_SEG && is_rd && !big |=> resp_pulse_out;
    endproperty
    a_rdend: assert property (p_rdend) else $error("read end no response");

    property p_stend;
        st == cfx_pkg::S_SEG && !is_rd && !big |=>
            st == cfx_pkg::S_IDLE && !resp_pulse_out;
    endproperty
    a_stend: assert property (p_stend) else $error("store end wrong");

    property p_store_resp;
        in_dec && fn == `CFX_FN_BLKST |=> resp_pulse_out ##1 st == cfx_pkg::S_WAIT;
    endproperty
    a_store_resp: assert property (p_store_resp) else $error("store start wrong");

    property p_foreign;
        st == cfx_pkg::S_IDLE && fn_valid_in && !id_hit |=> st == cfx_pkg::S_IDLE;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign packet taken");
endmodule : cfx_executor
`default_nettype wire

// ===== cfx_node_model.sv
`default_nettype none
module cfx_node_model (
    input wire logic clk_in, // clock
    input wire logic pulse_in, // data pulse from dut
    input wire logic tx_valid_in, // word offered
    output logic tx_ready_out, // stalls every other cycle
    output logic pulse_out, // data pulse back
    output int got_out // words taken
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_n = 0; // cycles until reply
    initial begin
        tx_ready_out = 0;
        pulse_out = 0;
        got_out = 0;
    end
    // reply late so a whole 64 word segment drains first
    always @(negedge clk_in) begin
        tx_ready_out = !tx_ready_out;
        pulse_out = (wait_n == 1);
        if (wait_n > 0) wait_n--;
        if (pulse_in) wait_n = 160;
    end
    always @(posedge clk_in) if (tx_valid_in && tx_ready_out) got_out++;
endmodule : cfx_node_model
`default_nettype wire

// ===== cfx_params.svh
`ifndef CFX_PARAMS_SVH
`define CFX_PARAMS_SVH
// function codes, octal 10..37 written in hex
`define CFX_FN_LDREG 5'h08
`define CFX_FN_STREG 5'h09
`define CFX_FN_RESTART 5'h0A
`define CFX_FN_STOP 5'h0B
`define CFX_FN_RDP 5'h0C
`define CFX_FN_LDP 5'h0D
`define CFX_FN_RDREG 5'h0E
`define CFX_FN_WRREG 5'h0F
`define CFX_FN_BLKRD 5'h10
`define CFX_FN_RDW 5'h11
`define CFX_FN_RDHI 5'h12
`define CFX_FN_RDLO 5'h13
`define CFX_FN_BRD 5'h16
`define CFX_FN_BREF 5'h17
`define CFX_FN_BLKST 5'h18
`define CFX_FN_WRW 5'h19
`define CFX_FN_WRHI 5'h1A
`define CFX_FN_WRLO 5'h1B
`define CFX_FN_BWR 5'h1E
`define CFX_FN_BSET 5'h1F
// subfunction register selects
`define CFX_SUB_STAT 2'h0
`define CFX_SUB_MAR 2'h1
`define CFX_SUB_ERR 2'h2
// segment size and forced lengths
`define CFX_SEG_LEN 10'h040
`define CFX_SEG_W 7'h40
`define CFX_LEN_ONE 10'h001
`define CFX_LEN_TWO 10'h002
`define CFX_LEN_FOUR 10'h004
`define CFX_FIFO_DEPTH 16
`endif

// ===== cfx_pkg.sv
`default_nettype none
package cfx_pkg;
    // one function packet, four 16-bit parcels
    typedef struct packed {
        logic [15:0] p1;
        logic [15:0] p2;
        logic [15:0] p3;
        logic [15:0] p4;
    } cfx_pkt_t;
    // commands to the processor core, all pulses
    typedef struct packed {
        logic start;
        logic stop;
        logic p_load;
        logic st_we;
        logic er_we;
        logic [31:0] pval;
        logic [31:0] rval;
    } cfx_cmd_t;
    // common memory request, one word at a time
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [63:0] wdata;
    } cfx_mem_t;
    typedef enum logic [3:0] {
        S_IDLE, S_DEC, S_MRD, S_MWR, S_PULSE,
        S_SEND, S_WAIT, S_RECV, S_SEG, S_RESP
    } cfx_state_t;
endpackage : cfx_pkg
`default_nettype wire

// ===== tb_channel_function_executor.sv
`include "cfx_params.svh"
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_channel_function_executor;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, vld = 0, ack = 0, dpi, dpo, txv, txr, rsp;
    logic [31:0] rd;
    logic [15:0] crr;
    cfx_pkg::cfx_pkt_t pkt = '0;
    cfx_pkg::cfx_mem_t mem;
    cfx_pkg::cfx_cmd_t cmd;
    logic [63:0] rdat = '0, lastw = '0;
    logic rdy, rxr, rxv = 0, kick = 0;
    logic [63:0] rxd = '0, txd, lastt = '0;
    logic [31:0] lasta = '0;
    int bad_count = 0, checks = 0, got;
    always #12.5 clk = ~clk;
    cfx_executor dut (.sys_clk_in(clk), .rst_in(rst), .fn_valid_in(vld), .fn_pkt_in(pkt),
        .fn_ready_out(rdy), .resp_pulse_out(rsp), .resp_data_out(rd), .crr_out(crr),
        .dpulse_in(dpi || kick), .dpulse_out(dpo), .rx_valid_in(rxv), .rx_data_in(rxd),
        .rx_ready_out(rxr), .tx_valid_out(txv), .tx_data_out(txd), .tx_ready_in(txr),
        .mem_out(mem), .mem_ack_in(ack), .mem_rdata_in(rdat), .pc_in(32'h1234_5678),
        .status_in(32'h0bad_0001), .errdata_in(32'h0000_00e5), .cmd_out(cmd));
    cfx_node_model node (.clk_in(clk), .pulse_in(dpo), .tx_valid_in(txv),
        .tx_ready_out(txr), .pulse_out(dpi), .got_out(got));
    // memory acks every other cycle while a request is up, data is {~addr, addr}
    always @(negedge clk) begin
        ack = mem.req && !ack;
        rdat = {~mem.addr, mem.addr};
        if (ack && mem.we) begin
            lastw = mem.wdata;
            lasta = mem.addr;
        end
    end
    // last word the node took off the outbound queue
    always @(posedge clk) if (txv && txr) lastt <= txd;
    // one packet, id bits match the default id, then wait for the answer
    task automatic fn(input logic [4:0] f, input logic [1:0] s, input logic [15:0] p2,
        input logic [31:0] v, input logic [31:0] exp);
        @(negedge clk);
        pkt = {2'b01, f, 2'b10, 5'h00, s, p2, v};
        vld = 1;
        @(negedge clk);
        vld = 0;
        for (int i = 0; i < 1000 && !rsp; i++) @(negedge clk);
        `CHK("pulse", 1'b1, rsp)
        `CHK("data", exp, rd)
    endtask : fn
    task t_core;
        fn(`CFX_FN_STOP, 0, 0, 0, 0); `CHK("stop", 1'b1, cmd.stop)
        fn(`CFX_FN_RDP, 0, 0, 0, 32'h1234_5678);
        fn(`CFX_FN_LDP, 0, 0, 32'ha5a5_0f0f, 0); `CHK("pval", 32'ha5a5_0f0f, cmd.pval)
        fn(`CFX_FN_RESTART, 0, 16'h00c3, 0, 0); `CHK("crr", 16'h00c3, crr)
        `CHK("start", 1'b1, cmd.start)
    endtask : t_core
    task t_regs;
        fn(`CFX_FN_WRREG, `CFX_SUB_MAR, 16'h0077, 32'h0000_0400, 0);
        `CHK("crr", 16'h0077, crr)
        fn(`CFX_FN_RDREG, `CFX_SUB_MAR, 0, 0, 32'h0000_0400);
        fn(`CFX_FN_RDREG, `CFX_SUB_STAT, 0, 0, 32'h0bad_0001);
        fn(`CFX_FN_RDREG, `CFX_SUB_ERR, 0, 0, 32'h0000_00e5);
        fn(`CFX_FN_WRREG, `CFX_SUB_STAT, 16'h0011, 32'h0000_abcd, 0);
        `CHK("st_we", 1'b1, cmd.st_we)
        `CHK("rval", 32'h0000_abcd, cmd.rval)
        `CHK("crr", 16'h0011, crr)
    endtask : t_regs
    // a packet for another interface must be ignored
    task automatic t_foreign;
        logic seen = 0;
        @(negedge clk);
        pkt = {2'b10, `CFX_FN_RDP, 2'b10, 7'h00, 48'h0};
        vld = 1;
        repeat (4) begin
            @(negedge clk);
            vld = 0;
            seen = seen | rsp;
        end
        `CHK("foreign", 1'b0, seen)
        `CHK("ready", 1'b1, rdy)
    endtask : t_foreign
    task t_refs;
        fn(`CFX_FN_WRHI, 0, 0, 32'h1111_2222, 0);
        fn(`CFX_FN_WRLO, 0, 0, 32'h3333_4444, 0);
        fn(`CFX_FN_RDHI, 0, 0, 0, 32'h1111_2222);
        fn(`CFX_FN_WRW, 0, 0, 32'h0000_0100, 0);
        `CHK("word", 64'h1111_2222_3333_4444, lastw)
        fn(`CFX_FN_BSET, 0, 16'h0005, 0, 0);
        fn(`CFX_FN_RDW, 0, 0, 32'h0000_0200, 0);
        fn(`CFX_FN_RDHI, 0, 0, 0, 32'hffff_fdff);
        fn(`CFX_FN_RDLO, 0, 0, 0, 32'h0000_0200);
        fn(`CFX_FN_BREF, 0, 16'h0005, 0, 0);
        fn(`CFX_FN_RDHI, 0, 0, 0, 32'h1111_2222);
        fn(`CFX_FN_RDLO, 0, 0, 0, 32'h3333_4444);
    endtask : t_refs
    task t_block;
        fn(`CFX_FN_BLKRD, 0, 16'h0042, 32'h0000_1000, 0);
        `CHK("words", 66, got)
        `CHK("last word", 64'hffff_efbe_0000_1041, lastt)
    endtask : t_block
    task t_mem;
        fn(`CFX_FN_STOP, 0, 0, 0, 0);
        fn(`CFX_FN_LDREG, 0, 16'h0055, 32'h0000_0500, 0);
        `CHK("ld pval", 32'h0000_0500, cmd.pval)
        `CHK("ld rval", 32'h0000_0501, cmd.rval)
        `CHK("ld start", 1'b1, cmd.start)
        `CHK("ld crr", 16'h0055, crr)
        fn(`CFX_FN_STREG, 0, 0, 32'h0000_0600, 0);
        `CHK("sv word", 64'h0000_0000_0bad_0001, lastw)
        `CHK("sv addr", 32'h0000_0601, lasta)
        fn(`CFX_FN_BRD, 0, 16'h0002, 32'h0000_0700, 0);
        fn(`CFX_FN_BWR, 0, 16'h0002, 32'h0000_0800, 0);
        `CHK("bwr word", 64'hffff_f8fe_0000_0701, lastw)
        `CHK("bwr addr", 32'h0000_0801, lasta)
    endtask : t_mem
    // three word store: pulse, words in, memory writes, pulse back, silent end
    task automatic t_store;
        logic sawp = 0;
        logic seen = 0;
        fn(`CFX_FN_BLKST, 0, 16'h0003, 32'h0000_3000, 0);
        @(negedge clk);
        kick = 1;
        @(negedge clk);
        kick = 0;
        `CHK("rx ready", 1'b1, rxr)
        rxv = 1;
        for (int i = 0; i < 3; i++) begin
            rxd = 64'h0000_0000_0000_0a00 + 64'(i);
            @(negedge clk);
        end
        rxv = 0;
        for (int i = 0; i < 40 && !rdy; i++) begin
            @(negedge clk);
            sawp = sawp | dpo;
            seen = seen | rsp;
        end
        `CHK("pulse back", 1'b1, sawp)
        `CHK("store word", 64'h0000_0000_0000_0a02, lastw)
        `CHK("store addr", 32'h0000_3002, lasta)
        `CHK("store quiet", 1'b0, seen)
        `CHK("idle", 1'b1, rdy)
    endtask : t_store
    task end_of_test;
        if (bad_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (3) @(negedge clk);
        rst = 0;
        t_core();
        t_regs();
        t_foreign();
        t_refs();
        t_mem();
        t_block();
        t_store();
        end_of_test();
    end
    initial begin
        #500000;
        bad_count++;
        end_of_test();
    end
endmodule : tb_channel_function_executor
`default_nettype wire
